// ---- common/ctp_params.svh ----
// constants for the processor timer control and prescaler block
// assumes a 16-bit processor memory bus with word addressing
`ifndef CTP_PARAMS_SVH
`define CTP_PARAMS_SVH

// =====================================================================
// register word offsets inside the timer's address window
`define CTP_ADDR_W            3
`define CTP_OFF_CONTROL       3'h4
`define CTP_OFF_PRESCALE_LOW  3'h6

// =====================================================================
// control register field positions
`define CTP_BIT_FLAG          15
`define CTP_BIT_IRQ_EN        14
`define CTP_BIT_FREE          11
`define CTP_BIT_SOFT          10
`define CTP_BIT_RELOAD        5
`define CTP_BIT_STOP          4
`define CTP_RSV_HI_MSB        9
`define CTP_RSV_HI_LSB        6
`define CTP_RSV_LO_MSB        3
`define CTP_RSV_LO_LSB        0

// =====================================================================
// prescale register field positions, and prescale and control register reset values
`define CTP_DIV_MSB           7
`define CTP_DIV_LSB           0
`define CTP_PSC_MSB           15
`define CTP_PSC_LSB           8
`define CTP_DIV_RESET         8'h00
`define CTP_PSC_RESET         16'h0000
`define CTP_CONTROL_RESET     16'h0000

`endif

// ---- common/ctp_pkg.sv ----
// types shared by the timer control and prescaler block
// assumes ctp_params.svh is on the include path
`default_nettype none

package ctp_pkg;
    typedef logic [15:0] ctp_word_t;
    typedef logic [31:0] ctp_count_t;
endpackage : ctp_pkg

`default_nettype wire

// ---- hdl/ctp_timer_ctrl.sv ----
// control and prescaler logic of a 32-bit down-counting processor timer
// assumes the main counter and period registers live outside and follow
// the decrement and reload strobes of this block on the same clock
`default_nettype none
`include "ctp_params.svh"

module ctp_timer_ctrl
    import ctp_pkg::*;
(
    // clock, reset and clock enable
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    clk_en,
    // processor memory bus
    input  wire logic                    bus_sel,
    input  wire logic                    bus_wr,
    input  wire logic                    bus_rd,
    input  wire logic [`CTP_ADDR_W-1:0]  bus_addr,
    input  wire ctp_word_t               bus_wdata,
    output logic      [15:0]             bus_rdata,
    // debugger breakpoint halt, asynchronous
    input  wire logic                    debug_halt,
    // companion prescale-high register
    input  wire logic [7:0]              divide_down_high,
    output logic      [7:0]              prescale_count_high,
    // main counter link
    input  wire ctp_count_t              main_count,
    output logic                         main_count_decrement,
    output logic                         main_count_reload,
    // interrupt request
    output logic                         timer_irq_out
);

    // =================================================================
    // reset release and halt synchroniser
    logic       rst_meta;
    logic       rst_sync_n;
    logic       halt_meta;
    logic       halt_sync;

    // reset released through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // debug halt pin passes two flops
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            halt_meta <= 1'b0;
            halt_sync <= 1'b0;
        end else if (clk_en) begin
            halt_meta <= debug_halt;
            halt_sync <= halt_meta;
        end
    end

    // =================================================================
    // control register state
    logic       zero_reached_flag;
    logic       zero_irq_enable;
    logic       free_run;
    logic       soft_stop;
    logic       run_stop_bit;
    logic [3:0] spare_hi;
    logic [3:0] spare_lo;
    logic [7:0] divide_down_low;
    logic [15:0] prescale_count;
    logic       halt_latched;

    // bus decode
    logic       wr_control;
    logic       wr_prescale;
    logic       reload_strobe;
    assign wr_control    = bus_sel && bus_wr &&
                           (bus_addr == `CTP_OFF_CONTROL);
    assign wr_prescale   = bus_sel && bus_wr &&
                           (bus_addr == `CTP_OFF_PRESCALE_LOW);
    assign reload_strobe = wr_control &&
                           bus_wdata[`CTP_BIT_RELOAD];

    // =================================================================
    // tick and zero decisions
    logic [15:0] divide_down;
    logic        running;
    logic        tick;
    logic        zero_event;
    assign divide_down = {divide_down_high, divide_down_low};
    assign running     = !run_stop_bit && !halt_latched;
    assign tick        = running && (prescale_count == 16'h0000);
    // decrement landing on zero
    assign zero_event  = tick && (main_count == 32'h0000_0001);

    // =================================================================
    // writable control fields
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            zero_irq_enable <= 1'b0;
            free_run        <= 1'b0;
            soft_stop       <= 1'b0;
            run_stop_bit    <= 1'b0;
            spare_hi        <= 4'h0;
            spare_lo        <= 4'h0;
        end else if (clk_en && wr_control) begin
            zero_irq_enable <= bus_wdata[`CTP_BIT_IRQ_EN];
            free_run        <= bus_wdata[`CTP_BIT_FREE];
            soft_stop       <= bus_wdata[`CTP_BIT_SOFT];
            run_stop_bit    <= bus_wdata[`CTP_BIT_STOP];
            spare_hi        <= bus_wdata[`CTP_RSV_HI_MSB:`CTP_RSV_HI_LSB];
            spare_lo        <= bus_wdata[`CTP_RSV_LO_MSB:`CTP_RSV_LO_LSB];
        end
    end

    // zero flag: set wins over a write-one clear
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            zero_reached_flag <= 1'b0;
        end else if (clk_en) begin
            if (zero_event) begin
                zero_reached_flag <= 1'b1;
            end else if (wr_control && bus_wdata[`CTP_BIT_FLAG]) begin
                zero_reached_flag <= 1'b0;
            end
        end
    end

    // divide-down low byte
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            divide_down_low <= `CTP_DIV_RESET;
        end else if (clk_en && wr_prescale) begin
            divide_down_low <= bus_wdata[`CTP_DIV_MSB:`CTP_DIV_LSB];
        end
    end

    // =================================================================
    // prescale counter, loaded by software only through the reload bit
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            prescale_count <= `CTP_PSC_RESET;
        end else if (clk_en) begin
            if (reload_strobe) begin
                prescale_count <= divide_down;
            end else if (tick) begin
                prescale_count <= divide_down;
            end else if (running && prescale_count != 16'h0000) begin
                prescale_count <= prescale_count - 16'h0001;
            end
        end
    end

    // =================================================================
    // debug halt: latches after the qualifying decrement
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            halt_latched <= 1'b0;
        end else if (clk_en) begin
            if (!halt_sync || free_run) begin
                halt_latched <= 1'b0;
            end else if (tick && !soft_stop) begin
                halt_latched <= 1'b1;
            end else if (zero_event && soft_stop) begin
                halt_latched <= 1'b1;
            end
        end
    end

    // =================================================================
    // main counter strobes, same cycle as the tick
    always_comb begin
        main_count_reload    = clk_en &&
            (reload_strobe || (tick && main_count == 32'h0000_0000));
        main_count_decrement = clk_en && !main_count_reload && tick;
    end
    // every strobe is qualified on the single system clock

    // interrupt pulse one cycle after zero event
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            timer_irq_out <= 1'b0;
        end else if (clk_en) begin
            timer_irq_out <= zero_event && zero_irq_enable;
        end
    end

    // =================================================================
    // read data, registered; unmapped reads zero
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            bus_rdata <= 16'h0000;
        end else if (clk_en) begin
            if (bus_sel && bus_rd && bus_addr == `CTP_OFF_CONTROL) begin
                bus_rdata <= {zero_reached_flag, zero_irq_enable, 2'b00,
                              free_run, soft_stop, spare_hi,
                              1'b0, run_stop_bit, spare_lo};
            end else if (bus_sel && bus_rd &&
                         bus_addr == `CTP_OFF_PRESCALE_LOW) begin
                bus_rdata <= {prescale_count[7:0], divide_down_low};
            end else begin
                bus_rdata <= 16'h0000;
            end
        end
    end

    // high byte of prescale count for the companion register
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            prescale_count_high <= 8'h00;
        end else if (clk_en) begin
            prescale_count_high <= prescale_count[15:8];
        end
    end

endmodule : ctp_timer_ctrl

`default_nettype wire

// ---- tb/ctp_timer_ctrl_properties.sv ----
// checker for the timer control and prescaler ports
// assumes it is bound onto ctp_timer_ctrl, one clock domain
`default_nettype none
`include "ctp_params.svh"

// ====
// port relations of the timer control block
module ctp_checker
    import ctp_pkg::*;
(
    // clock and enables
    input wire logic                   clk,
    input wire logic                   rst_n,
    input wire logic                   clk_en,
    // register bus
    input wire logic                   bus_sel,
    input wire logic                   bus_wr,
    input wire logic                   bus_rd,
    input wire logic [`CTP_ADDR_W-1:0] bus_addr,
    input wire ctp_word_t              bus_wdata,
    input wire logic [15:0]            bus_rdata,
    // main counter link and interrupt
    input wire ctp_count_t             main_count,
    input wire logic                   main_count_decrement,
    input wire logic                   main_count_reload,
    input wire logic                   timer_irq_out
);
    // settle delay, covers the reset synchroniser
    logic [2:0] up;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            up <= 3'h0;
        end else begin
            up <= {up[1:0], 1'b1};
        end
    end
    wire logic ctl = bus_addr == `CTP_OFF_CONTROL;
    wire logic rd  = clk_en && bus_sel && bus_rd;
    wire logic rl  = clk_en && bus_sel && bus_wr && ctl && bus_wdata[5];

    default clocking @(posedge clk); endclocking
    default disable iff (!up[2]);

    // decrement from one, then the interrupt cycle
    sequence s_hit;
        main_count_decrement && main_count == 32'h1;
    endsequence
    sequence s_irq_after_hit;
        s_hit ##1 timer_irq_out;
    endsequence

    a_irq_cause: assert property (timer_irq_out |->
        $past(main_count_decrement && main_count == 32'h1))
        else $error("interrupt without a zero event");
    a_irq_pulse: assert property (s_irq_after_hit |=> !timer_irq_out)
        else $error("interrupt longer than one cycle");
    a_reload_write: assert property (rl |-> main_count_reload
        && !main_count_decrement)
        else $error("reload write without reload strobe");
    a_reload_cause: assert property (main_count_reload |->
        rl || main_count == 32'h0)
        else $error("reload strobe without cause");
    a_zero_reloads: assert property (main_count_decrement |->
        main_count != 32'h0)
        else $error("decrement at zero instead of reload");
    a_freeze_strobes: assert property (!clk_en |->
        !main_count_decrement && !main_count_reload)
        else $error("strobe while clock enable low");
    a_rdata_idle: assert property (!$past(rd) |-> bus_rdata == 16'h0000)
        else $error("read data outside a read");
    a_reload_reads0: assert property ($past(rd && ctl) |->
        bus_rdata[5] == 1'b0 && bus_rdata[13:12] == 2'h0)
        else $error("reload or reserved bit reads nonzero");
endmodule : ctp_checker

bind ctp_timer_ctrl ctp_checker u_chk (.clk(clk), .rst_n(rst_n),
    .clk_en(clk_en), .bus_sel(bus_sel), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .main_count(main_count), .main_count_decrement(main_count_decrement),
    .main_count_reload(main_count_reload), .timer_irq_out(timer_irq_out));

`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the timer control and prescaler block
// assumes ctp_params.svh on the include path; models the main counter
`default_nettype none
`include "ctp_params.svh"

// ====
// bench top
module testbench
    import ctp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk, rst_n, clk_en, bus_sel, bus_wr, bus_rd, debug_halt;
    logic [2:0] bus_addr;
    ctp_word_t  bus_wdata, bus_rdata, got;
    logic [7:0] div_high, psc_high;
    ctp_count_t cnt, period;
    logic       dec, rld, irq;
    int         num_errors, total_checks, decs, irqs, his, n;
    int         cyc = 0;
    // rows: address, write data, read back
    localparam logic [34:0] ROWS [8] = '{
        {3'h4, 16'h0010, 16'h0010}, {3'h6, 16'h00A5, 16'h00A5},
        {3'h4, 16'h0030, 16'h0010}, {3'h6, 16'h12A5, 16'hA5A5},
        {3'h6, 16'h0000, 16'hA500}, {3'h5, 16'hFFFF, 16'h0000},
        {3'h4, 16'hFFFF, 16'h4FDF}, {3'h4, 16'h0000, 16'h0000}};

    ctp_timer_ctrl dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
        .bus_sel(bus_sel), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .debug_halt(debug_halt), .divide_down_high(div_high),
        .prescale_count_high(psc_high), .main_count(cnt),
        .main_count_decrement(dec), .main_count_reload(rld),
        .timer_irq_out(irq));

    // clock source
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // main counter and period outside the block
    always @(posedge clk) begin
        if (rld) begin
            cnt <= period;
        end else if (dec) begin
            cnt <= cnt - 32'h1;
        end
    end
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            stop_test();
        end
    end

    task automatic chk(input logic ok);
        total_checks++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("CHECK FAILED at %0t: value mismatch", $time);
        end
    endtask : chk

    // one bus access, write when w is high
    task automatic acc(input logic [2:0] a, input ctp_word_t d,
                       input logic w);
        @(posedge clk);
        bus_sel <= 1'b1;
        bus_wr <= w;
        bus_rd <= !w;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk);
        bus_sel <= 1'b0;
        bus_wr <= 1'b0;
        bus_rd <= 1'b0;
        #1 got = bus_rdata;
    endtask : acc

    // count strobes over c cycles
    task automatic run(input int c);
        decs = 0;
        irqs = 0;
        his = 0;
        repeat (c) begin
            @(negedge clk);
            decs += int'(dec === 1'b1);
            irqs += int'(irq === 1'b1);
            his += int'(psc_high === 8'h01);
        end
    endtask : run

    // cycles between two decrements
    task automatic gap(input int e);
        n = 0;
        run(1);
        while (decs == 0 && n < 600) begin
            run(1);
            n++;
        end
        n = 0;
        do begin
            run(1);
            n++;
        end while (decs == 0 && n < 600);
        chk(n == e);
    endtask : gap

    task automatic stop_test();
        if (num_errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test

    // ====
    // main sequence
    initial begin
        {rst_n, bus_sel, bus_wr, bus_rd, debug_halt} = 5'h00;
        {clk_en, bus_addr, bus_wdata, div_high} = 28'h8000000;
        {cnt, period} = {32'h0, 32'h10000};
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (ROWS[i]) begin
            acc(ROWS[i][34:32], ROWS[i][31:16], 1'b1);
            acc(ROWS[i][34:32], 16'h0000, 1'b0);
            chk(got === ROWS[i][15:0]);
        end
        acc(3'h6, 16'h0002, 1'b1);
        acc(3'h4, 16'h0020, 1'b1);
        gap(3);
        div_high <= 8'h01;
        acc(3'h6, 16'h0000, 1'b1);
        acc(3'h4, 16'h0020, 1'b1);
        gap(257);
        run(257);
        chk(decs == 1 && his == 1);
        div_high <= 8'h00;
        acc(3'h6, 16'h0000, 1'b1);
        clk_en <= 1'b0;
        run(5);
        chk(decs == 0);
        clk_en <= 1'b1;
        acc(3'h4, 16'h0010, 1'b1);
        run(10);
        chk(decs == 0);
        period = 32'h3;
        acc(3'h4, 16'h4020, 1'b1);
        run(12);
        chk(irqs == 3 && decs == 9);
        acc(3'h4, 16'h4010, 1'b1);
        acc(3'h4, 16'h0000, 1'b0);
        chk(got === 16'hC010);
        acc(3'h4, 16'hC010, 1'b1);
        acc(3'h4, 16'h0000, 1'b0);
        chk(got === 16'h4010);
        acc(3'h4, 16'h0000, 1'b1);
        run(12);
        chk(irqs == 0);
        acc(3'h4, 16'h0800, 1'b1);
        debug_halt <= 1'b1;
        run(12);
        chk(decs == 9);
        acc(3'h4, 16'h0000, 1'b1);
        run(4);
        run(8);
        chk(decs == 0);
        debug_halt <= 1'b0;
        acc(3'h4, 16'h4420, 1'b1);
        debug_halt <= 1'b1;
        run(12);
        chk(irqs == 1);
        run(8);
        chk(decs == 0 && cnt === 32'h0);
        debug_halt <= 1'b0;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        acc(3'h4, 16'h0000, 1'b0);
        chk(got === 16'h0000);
        acc(3'h6, 16'h0000, 1'b0);
        chk(got === 16'h0000);
        run(4);
        chk(decs > 0);
        stop_test();
    end
endmodule : testbench

`default_nettype wire
